// file: inc/supervisor_pkg.sv
// constants for the supply supervisor and watchdog block
// assumes one 20 MHz clock; counts are in crystal clocks
package supervisor_pkg;
   localparam logic [7:0] clock_control_addr   = 8'h8E;
   localparam logic [7:0] watchdog_control_addr = 8'hD8;
   localparam logic [7:0] ext_irq_enable_addr  = 8'hE8;
   localparam logic [7:0] timed_access_addr    = 8'hC7;
   localparam logic [7:0] unlock_key_first     = 8'hAA;
   localparam logic [7:0] unlock_key_second    = 8'h55;
   localparam int         unlock_window_clocks = 3;
   localparam int         stabilise_clocks     = 65536;
   localparam int         pre_reset_clocks     = 512;
   localparam int         timeout_exp_base     = 17;
   localparam int         timeout_exp_step     = 3;
   localparam int         dog_count_width      = 27;
   localparam int         dog_reset_pulse      = 4;
   localparam int         sel_hi_bit           = 7;
   localparam int         sel_lo_bit           = 6;
   localparam int         pf_enable_bit        = 5;
   localparam int         pf_flag_bit          = 4;
   localparam int         dog_irq_flag_bit     = 3;
   localparam int         dog_reset_flag_bit   = 2;
   localparam int         dog_enable_bit       = 1;
   localparam int         dog_restart_bit      = 0;
   localparam int         dog_irq_enable_bit   = 4;
   localparam logic [7:0] clock_control_reset  = 8'h01;
   localparam logic [7:0] pf_vector            = 8'h33;
   localparam logic [7:0] dog_vector           = 8'h63;
endpackage

// file: core/supervisor_watchdog_powerfail.sv
// supply supervisor: power-on hold, brown-out reset, power-warning
// interrupt and watchdog with pre-reset interrupt and timed access.
// assumes comparator levels are asynchronous; register port is core-timed.
//
// Contract
// - hold reset below threshold, then count 65536
// - supply drop asserts reset while below threshold
// - enabled power warning vectors to 0033h
// - power warning interrupt beats all others
// - control bit 5 enables power warning interrupt
// - bit 4 flags warning, sticky until cleared
// - enabled watchdog resets unless restarted in time
// - enable and restart change only via timed access
// - interval counted in crystal clocks
// - interrupt raised 512 clocks before watchdog reset
// - watchdog interrupt wakes core from idle
// - clock control bits 7:6 select timeout
// - control spread over three registers
// - interrupt points 2^17,2^20,2^23,2^26 clocks
// - reset follows 512 clocks regardless of enable
// - bit 3 interrupt flag, bit 2 reset flag
// - bit1 enables, bit0 restarts, irq-enable bit 4
`timescale 1ns/1ps
module supervisor_watchdog_powerfail #(
   parameter int stabilise_count = supervisor_pkg::stabilise_clocks, // power-on hold length
   parameter int pre_reset_count = supervisor_pkg::pre_reset_clocks, // irq to reset gap
   parameter int timeout_shift   = 0                                  // shortens intervals in sim
)(
   input  wire logic       mclk,            // crystal clock
   input  wire logic       reset_n,         // synchronous reset, active low
   input  wire logic       below_reset_in,  // supply under reset threshold (async)
   input  wire logic       below_warn_in,   // supply under warning threshold (async)
   input  wire logic       osc_running_in,  // oscillator running (async)
   input  wire logic [7:0] reg_addr,        // register address
   input  wire logic [7:0] reg_wdata,       // write data
   input  wire logic       reg_wr,          // write strobe
   input  wire logic       reg_rd,          // read strobe
   input  wire logic       core_idle,       // core is in idle
   input  wire logic       other_irq_req,   // any lower-priority request pending
   input  wire logic [7:0] other_irq_vector,// its vector
   output logic [7:0]      reg_rdata,       // read data, valid cycle after rd
   output logic            core_reset,      // reset to the core, active high
   output logic            irq_req,         // interrupt request to core
   output logic [7:0]      irq_vector,      // vector of winning request
   output logic            idle_wake        // pulse ending idle
);
   // counters are sized for twice the documented defaults; larger counts stop elaboration with an error
   if (timeout_shift < 0 || timeout_shift > 16 ||
       pre_reset_count < 1 || pre_reset_count > 1024 ||
       stabilise_count < 1 || stabilise_count > 131072)
   begin : g_param_check
      $error("supervisor: parameter out of range");
   end

   typedef enum logic [1:0] {st_hold, st_stabilise, st_run, st_dog_reset} sup_e;

   typedef struct packed {
      logic [1:0] below_rst_sync;
      logic [1:0] below_warn_sync;
      logic [1:0] osc_sync;
      logic       warn_prev;
      sup_e       state;
      logic [16:0] stab_cnt;
      logic [26:0] dog_cnt;
      logic        in_pre_reset;
      logic [9:0]  pre_cnt;
      logic [2:0]  pulse_cnt;
      logic [7:0]  clock_control;
      logic        pf_enable;
      logic        pf_flag;
      logic        dog_irq_flag;
      logic        dog_reset_flag;
      logic        dog_enable;
      logic        dog_irq_enable;
      logic [1:0]  ta_step;
      logic [1:0]  ta_timer;
      logic [7:0]  rdata;
      logic        core_reset;
      logic        irq_req;
      logic [7:0]  irq_vector;
      logic        idle_wake;
   } state_s;

   state_s s_r;
   state_s s_nxt;

   // interval in clocks: 2^(17 + 3*select), optionally shortened for simulation
   function automatic logic [26:0] interval_of(input logic [1:0] sel);
      int e;
      e = supervisor_pkg::timeout_exp_base + supervisor_pkg::timeout_exp_step * int'(sel) - timeout_shift;
      interval_of = 27'(1) << e;
   endfunction

   // one write strobe decoded against one register address
   function automatic logic write_hits(input logic wr, input logic [7:0] addr, input logic [7:0] target);
      write_hits = wr && addr == target;
   endfunction

   logic below_rst;
   logic below_warn;
   logic osc_ok;
   logic wr_ctl;
   logic unlocked;
   logic restart;
   logic [1:0] sel;

   always_comb
   begin
      s_nxt = s_r;
      // comparator levels are asynchronous: only the second flop is read
      below_rst  = s_r.below_rst_sync[1];
      below_warn = s_r.below_warn_sync[1];
      osc_ok     = s_r.osc_sync[1];
      s_nxt.below_rst_sync  = {s_r.below_rst_sync[0], below_reset_in};
      s_nxt.below_warn_sync = {s_r.below_warn_sync[0], below_warn_in};
      s_nxt.osc_sync        = {s_r.osc_sync[0], osc_running_in};
      s_nxt.warn_prev = below_warn;
      s_nxt.idle_wake = 1'b0;
      restart = 1'b0;
      unlocked = (s_r.ta_step == 2'd2);
      wr_ctl = write_hits(reg_wr, reg_addr, supervisor_pkg::watchdog_control_addr);
      sel = {s_r.clock_control[supervisor_pkg::sel_hi_bit],
             s_r.clock_control[supervisor_pkg::sel_lo_bit]};

      // timed access: key pair opens a short window for one protected write
      if (s_r.ta_timer != 2'd0)
         s_nxt.ta_timer = s_r.ta_timer - 2'd1;
      else
         s_nxt.ta_step = 2'd0;
      if (write_hits(reg_wr, reg_addr, supervisor_pkg::timed_access_addr))
      begin
         if (reg_wdata == supervisor_pkg::unlock_key_first)
         begin
            s_nxt.ta_step  = 2'd1;
            s_nxt.ta_timer = 2'(supervisor_pkg::unlock_window_clocks);
         end
         else if (reg_wdata == supervisor_pkg::unlock_key_second && s_r.ta_step == 2'd1)
         begin
            s_nxt.ta_step  = 2'd2;
            s_nxt.ta_timer = 2'(supervisor_pkg::unlock_window_clocks);
         end
         else
            s_nxt.ta_step = 2'd0;
      end

      // register writes; the three registers hold all watchdog control
      if (write_hits(reg_wr, reg_addr, supervisor_pkg::clock_control_addr))
         s_nxt.clock_control = reg_wdata;
      if (write_hits(reg_wr, reg_addr, supervisor_pkg::ext_irq_enable_addr))
         s_nxt.dog_irq_enable = reg_wdata[supervisor_pkg::dog_irq_enable_bit];
      if (wr_ctl)
      begin
         s_nxt.pf_enable = reg_wdata[supervisor_pkg::pf_enable_bit];
         if (!reg_wdata[supervisor_pkg::pf_flag_bit])
            s_nxt.pf_flag = 1'b0;
         if (!reg_wdata[supervisor_pkg::dog_irq_flag_bit])
            s_nxt.dog_irq_flag = 1'b0;
         if (!reg_wdata[supervisor_pkg::dog_reset_flag_bit])
            s_nxt.dog_reset_flag = 1'b0;
         if (unlocked)
         begin
            s_nxt.dog_enable = reg_wdata[supervisor_pkg::dog_enable_bit];
            restart = reg_wdata[supervisor_pkg::dog_restart_bit];
            s_nxt.ta_step = 2'd0;
         end
      end

      // sticky warning flag; a new warning edge beats a clear
      if (below_warn && !s_r.warn_prev)
         s_nxt.pf_flag = 1'b1;

      // brown-out and power-on share the hold state; the watchdog keeps its settings
      // across a supply dip, so software should check the reset flags after start-up
      case (s_r.state)
         st_hold:
         begin
            s_nxt.core_reset = 1'b1;
            s_nxt.stab_cnt = '0;
            if (!below_rst && osc_ok)
               s_nxt.state = st_stabilise;
         end
         st_stabilise:
         begin
            s_nxt.core_reset = 1'b1;
            s_nxt.stab_cnt = s_r.stab_cnt + 17'd1;
            if (below_rst)
               s_nxt.state = st_hold;
            else if (32'(s_r.stab_cnt) == stabilise_count - 1)
               s_nxt.state = st_run;
         end
         st_run:
         begin
            s_nxt.core_reset = 1'b0;
            if (!s_r.dog_enable || restart)
            begin
               s_nxt.dog_cnt = '0;
               s_nxt.in_pre_reset = 1'b0;
               s_nxt.pre_cnt = '0;
            end
            else if (!s_r.in_pre_reset)
            begin
               s_nxt.dog_cnt = s_r.dog_cnt + 27'd1;
               if (s_r.dog_cnt == interval_of(sel) - 27'd1)
               begin
                  s_nxt.in_pre_reset = 1'b1;
                  s_nxt.dog_irq_flag = 1'b1;
               end
            end
            else
            begin
               s_nxt.pre_cnt = s_r.pre_cnt + 10'd1;
               if (32'(s_r.pre_cnt) == pre_reset_count - 1)
               begin
                  s_nxt.state = st_dog_reset;
                  s_nxt.dog_reset_flag = 1'b1;
                  s_nxt.pulse_cnt = '0;
               end
            end
            if (below_rst)
               s_nxt.state = st_hold;
         end
         // control registers return to reset values; flags survive so software sees why
         st_dog_reset:
         begin
            s_nxt.core_reset = 1'b1;
            s_nxt.dog_enable = 1'b0;
            s_nxt.dog_cnt = '0;
            s_nxt.in_pre_reset = 1'b0;
            s_nxt.pre_cnt = '0;
            s_nxt.pf_enable = 1'b0;
            s_nxt.dog_irq_enable = 1'b0;
            s_nxt.clock_control = supervisor_pkg::clock_control_reset;
            s_nxt.pulse_cnt = s_r.pulse_cnt + 3'd1;
            if (below_rst)
               s_nxt.state = st_hold;
            else if (s_r.pulse_cnt == 3'(supervisor_pkg::dog_reset_pulse - 1))
               s_nxt.state = st_run;
         end
         default:
            s_nxt.state = st_hold;
      endcase

      // power warning outranks every source, watchdog sits lowest
      s_nxt.irq_req = 1'b0;
      s_nxt.irq_vector = s_r.irq_vector;
      if (s_r.pf_enable && below_warn)
      begin
         s_nxt.irq_req = 1'b1;
         s_nxt.irq_vector = supervisor_pkg::pf_vector;
      end
      else if (other_irq_req)
      begin
         s_nxt.irq_req = 1'b1;
         s_nxt.irq_vector = other_irq_vector;
      end
      else if (s_r.dog_irq_enable && s_r.dog_irq_flag)
      begin
         s_nxt.irq_req = 1'b1;
         s_nxt.irq_vector = supervisor_pkg::dog_vector;
      end
      if (core_idle && s_r.dog_irq_enable && s_r.dog_irq_flag)
         s_nxt.idle_wake = 1'b1;
      // no request may reach a core that is held in reset
      if (s_nxt.core_reset)
         s_nxt.irq_req = 1'b0;

      // read data is registered and stands for one cycle only
      s_nxt.rdata = 8'h00;
      if (reg_rd)
      begin
         case (reg_addr)
            supervisor_pkg::clock_control_addr: s_nxt.rdata = s_r.clock_control;
            supervisor_pkg::watchdog_control_addr:
               s_nxt.rdata = {2'b00, s_r.pf_enable, s_r.pf_flag, s_r.dog_irq_flag,
                              s_r.dog_reset_flag, s_r.dog_enable, 1'b0};
            supervisor_pkg::ext_irq_enable_addr: s_nxt.rdata = {3'b000, s_r.dog_irq_enable, 4'h0};
            default: s_nxt.rdata = 8'h00;
         endcase
      end
   end

   // synchronous reset: clear the struct, then the few non-zero reset values
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         s_r <= '0;
         s_r.state <= st_hold;
         s_r.core_reset <= 1'b1;
         s_r.clock_control <= supervisor_pkg::clock_control_reset;
      end
      else
         s_r <= s_nxt;
   end

   assign reg_rdata  = s_r.rdata;
   assign core_reset = s_r.core_reset;
   assign irq_req    = s_r.irq_req;
   assign irq_vector = s_r.irq_vector;
   assign idle_wake  = s_r.idle_wake;
endmodule

// file: sim/supervisor_properties.sv
// checker: port relations of the supply supervisor and watchdog
// assumes bind onto the top module with sim-sized counts
`timescale 1ns/1ps
module supervisor_properties #(
   parameter int stabilise_count = 16 // power-on hold length
)(
   input wire logic       mclk,           // clock
   input wire logic       reset_n,        // sync reset
   input wire logic       below_reset_in, // supply low
   input wire logic       below_warn_in,  // supply warning
   input wire logic       osc_running_in, // oscillator ok
   input wire logic       core_idle,      // core idle
   input wire logic       core_reset,     // core reset
   input wire logic       irq_req,        // irq request
   input wire logic [7:0] irq_vector,     // irq vector
   input wire logic       idle_wake       // idle wake
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   logic [15:0] good_r;
   logic        dog_v;
   logic        pf_v;
   assign dog_v = irq_req && irq_vector == supervisor_pkg::dog_vector;
   assign pf_v  = irq_req && irq_vector == supervisor_pkg::pf_vector;
   // counts clocks of good supply; saturates so long runs never wrap
   always_ff @(posedge mclk)
      if (!reset_n || below_reset_in || !osc_running_in)
         good_r <= '0;
      else if (good_r != 16'hFFFF)
         good_r <= good_r + 16'h0001;
   brownout_hold_a: assert property (below_reset_in [*5] |-> core_reset)
      else $error("core runs under low supply");
   hold_length_a: assert property ($fell(core_reset) |-> int'(good_r) >= stabilise_count)
      else $error("reset released early");
   hold_release_a: assert property (int'(good_r) == stabilise_count + 6 |-> !core_reset)
      else $error("reset held too long");
   dog_pulse_a: assert property ($rose(core_reset) && good_r > 16'h0008 |-> core_reset [*4] ##1 !core_reset)
      else $error("watchdog reset pulse wrong");
   dog_gap_a: assert property ($rose(dog_v) && !$past(core_reset, 2) |-> !core_reset [*7] ##[1:3] core_reset)
      else $error("irq to reset gap wrong");
   wake_idle_a: assert property (idle_wake |-> $past(core_idle))
      else $error("wake outside idle");
   wake_follows_a: assert property (core_idle [*3] ##0 dog_v |-> idle_wake)
      else $error("no wake from idle");
   pf_holds_a: assert property (pf_v ##1 below_warn_in && !core_reset |-> pf_v)
      else $error("power warning lost priority");
   cover property (dog_v);
   cover property (pf_v);
   cover property (idle_wake);
endmodule
bind supervisor_watchdog_powerfail supervisor_properties #(.stabilise_count(stabilise_count)) u_supervisor_properties (
   .mclk, .reset_n, .below_reset_in, .below_warn_in, .osc_running_in,
   .core_idle, .core_reset, .irq_req, .irq_vector, .idle_wake
);

// file: sim/supply_model.sv
// supply comparators and oscillator seen by the supervisor
// assumes the bench moves the supply levels at the falling edge
`timescale 1ns/1ps
module supply_model (
   input  wire logic mclk,           // crystal clock
   input  wire logic supply_low,     // supply under reset threshold
   input  wire logic supply_warn,    // supply under warning threshold
   output logic      below_reset_in, // reset comparator
   output logic      below_warn_in,  // warning comparator
   output logic      osc_running_in  // oscillator running
);
   logic [1:0] osc_cnt_r = 2'h0;
   // warning level sits above reset level, so a low supply trips both
   always_comb below_reset_in = supply_low;
   always_comb below_warn_in = supply_low || supply_warn;
   // oscillator only starts once the supply is good; counted on the rising edge
   // so it never races the bench, which moves the supply on the falling edge
   always @(posedge mclk)
      if (supply_low)
         osc_cnt_r <= 2'h0;
      else if (osc_cnt_r != 2'h3)
         osc_cnt_r <= osc_cnt_r + 2'h1;
   always_comb osc_running_in = osc_cnt_r == 2'h3;
endmodule

// file: sim/testbench.sv
// self-checking bench for the supply supervisor and watchdog
// assumes hold 16, pre-reset gap 8, shift 14 (8-clock shortest interval)
`timescale 1ns/1ps
module testbench;
   logic       mclk = 1'b0, reset_n = 1'b0, supply_low = 1'b1, supply_warn = 1'b0;
   logic       reg_wr = 1'b0, reg_rd = 1'b0, core_idle = 1'b0, other_irq_req = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, other_irq_vector = 8'h0B;
   logic [7:0] reg_rdata, irq_vector;
   logic       below_reset_in, below_warn_in, osc_running_in, core_reset, irq_req, idle_wake;
   int         err_total = 0, total_checks = 0, n;
   supply_model u_supply_model (.mclk, .supply_low, .supply_warn, .below_reset_in,
      .below_warn_in, .osc_running_in);
   supervisor_watchdog_powerfail #(.stabilise_count(16), .pre_reset_count(8), .timeout_shift(14))
      u_supervisor_watchdog_powerfail (.mclk, .reset_n, .below_reset_in, .below_warn_in,
      .osc_running_in, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .core_idle, .other_irq_req,
      .other_irq_vector, .reg_rdata, .core_reset, .irq_req, .irq_vector, .idle_wake);
   initial forever #25 mclk = ~mclk;
   task automatic chk(input logic [7:0] got, exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk_in(input int got, lo, hi);
      total_checks++;
      if (got < lo || got > hi)
      begin
         err_total++;
         $display("unexpected at %0t: count %0d", $time, got);
      end
   endtask
   // hold keeps the strobe up so the unlock keys land on adjacent clocks
   task automatic wr(input logic [7:0] a, d, input bit hold = 1'b0);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      if (!hold)
      begin
         @(negedge mclk);
         reg_wr = 1'b0;
      end
   endtask
   task automatic unlock_wr(input logic [7:0] d);
      wr(supervisor_pkg::timed_access_addr, supervisor_pkg::unlock_key_first, 1'b1);
      wr(supervisor_pkg::timed_access_addr, supervisor_pkg::unlock_key_second, 1'b1);
      wr(supervisor_pkg::watchdog_control_addr, d);
   endtask
   task automatic rd_chk(input logic [7:0] a, exp);
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge mclk);
      reg_rd = 1'b0;
      chk(reg_rdata, exp);
   endtask
   task automatic wait_rst(input logic lvl, input int lim);
      n = 0;
      while (core_reset !== lvl && n < lim)
      begin
         @(negedge mclk);
         n++;
      end
   endtask
   task automatic power_up;
      supply_low = 1'b0;
      wait_rst(1'b0, 60);
      chk_in(n, 19, 27);
      rd_chk(supervisor_pkg::clock_control_addr, supervisor_pkg::clock_control_reset);
      rd_chk(supervisor_pkg::watchdog_control_addr, 8'h00);
      rd_chk(8'h90, 8'h00);
   endtask
   task automatic dog_guard;
      wr(supervisor_pkg::watchdog_control_addr, 8'h02);
      rd_chk(supervisor_pkg::watchdog_control_addr, 8'h00);
      wr(supervisor_pkg::timed_access_addr, supervisor_pkg::unlock_key_first, 1'b1);
      wr(supervisor_pkg::timed_access_addr, 8'h11, 1'b1);
      wr(supervisor_pkg::watchdog_control_addr, 8'h02);
      rd_chk(supervisor_pkg::watchdog_control_addr, 8'h00);
      wr(supervisor_pkg::clock_control_addr, 8'h41);
      unlock_wr(8'h02);
      rd_chk(supervisor_pkg::watchdog_control_addr, 8'h02);
      wr(supervisor_pkg::watchdog_control_addr, 8'h00);
      rd_chk(supervisor_pkg::watchdog_control_addr, 8'h02);
      repeat (3)
      begin
         repeat (40) @(negedge mclk);
         unlock_wr(8'h03);
      end
      chk({7'h00, core_reset}, 8'h00);
      wait_rst(1'b1, 200);
      chk_in(n, 72, 77);
      repeat (6) @(negedge mclk);
      wr(supervisor_pkg::watchdog_control_addr, 8'h00);
   endtask
   task automatic dog_sel;
      bit seen, wk;
      for (int s = 0; s < 4; s++)
      begin
         wr(supervisor_pkg::clock_control_addr, {s[1:0], 6'h01});
         wr(supervisor_pkg::ext_irq_enable_addr, s == 0 ? 8'h10 : 8'h00);
         rd_chk(supervisor_pkg::ext_irq_enable_addr, s == 0 ? 8'h10 : 8'h00);
         core_idle = (s == 0);
         unlock_wr(8'h02);
         seen = 1'b0;
         wk = 1'b0;
         n = 0;
         while (core_reset !== 1'b1 && n < 6000)
         begin
            @(negedge mclk);
            n++;
            seen |= irq_req === 1'b1 && irq_vector === supervisor_pkg::dog_vector;
            wk |= idle_wake === 1'b1;
         end
         chk_in(n, (1 << (3 + 3 * s)) + 8, (1 << (3 + 3 * s)) + 12);
         chk({6'h00, seen, wk}, s == 0 ? 8'h03 : 8'h00);
         repeat (6) @(negedge mclk);
         core_idle = 1'b0;
         rd_chk(supervisor_pkg::watchdog_control_addr, 8'h0C);
         wr(supervisor_pkg::watchdog_control_addr, 8'h00);
      end
   endtask
   task automatic power_warn;
      supply_warn = 1'b1;
      repeat (5) @(negedge mclk);
      chk({7'h00, irq_req}, 8'h00);
      rd_chk(supervisor_pkg::watchdog_control_addr, 8'h10);
      wr(supervisor_pkg::watchdog_control_addr, 8'h20);
      other_irq_req = 1'b1;
      repeat (3) @(negedge mclk);
      chk({irq_req, 7'h00}, 8'h80);
      chk(irq_vector, supervisor_pkg::pf_vector);
      rd_chk(supervisor_pkg::watchdog_control_addr, 8'h20);
      supply_warn = 1'b0;
      repeat (5) @(negedge mclk);
      chk(irq_vector, other_irq_vector);
      other_irq_req = 1'b0;
      wr(supervisor_pkg::watchdog_control_addr, 8'h00);
   endtask
   task automatic brown_out;
      supply_low = 1'b1;
      wait_rst(1'b1, 8);
      chk_in(n, 1, 5);
      repeat (30) @(negedge mclk);
      chk({7'h00, core_reset}, 8'h01);
      supply_low = 1'b0;
      wait_rst(1'b0, 60);
      chk_in(n, 19, 27);
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(negedge mclk);
      reset_n = 1'b1;
      power_up;
      dog_guard;
      dog_sel;
      power_warn;
      brown_out;
      wrap_up;
   end
   // all scenarios together need about 5200 clocks
   initial
   begin
      repeat (20000) @(posedge mclk);
      err_total++;
      wrap_up;
   end
endmodule
